// ==== core/mid_pkg.sv ====
package mid_pkg;
    localparam int INSTR_W     = 16;
    localparam int DATA_W      = 8;
    localparam int MOD_W       = 4;
    localparam int SRC_IDX_W   = 4;
    localparam int DST_SUB_W   = 3;
    localparam int DST_IDX_W   = 5;
    localparam int PFX_W       = 2;
    localparam int FMT_BIT     = 15;
    localparam int SRC_LO      = 0;
    localparam int SRC_HI      = 7;
    localparam int SRC_MOD_LO  = 0;
    localparam int SRC_IDX_LO  = 4;
    localparam int DST_MOD_LO  = 8;
    localparam int DST_SUB_LO  = 12;
    localparam int PC_W        = 16;
    localparam int STACK_DEPTH = 4;
    localparam int SP_W        = 2;
    localparam int NUM_DP      = 3;
    localparam logic       FMT_IMM    = 1'b0;
    localparam logic [3:0] MOD_ACC    = 4'h9;
    localparam logic [3:0] MOD_PFX    = 4'hb;
    localparam logic [3:0] MOD_IP     = 4'hc;
    localparam logic [3:0] MOD_SP     = 4'hd;
    localparam logic [3:0] MOD_DP     = 4'hf;
    localparam logic [3:0] MOD_ALU    = 4'h8;
    localparam logic [3:0] IDX_PUSH   = 4'h0;
    localparam logic [3:0] IDX_CALL   = 4'h3;
    localparam logic [1:0] SP_RESET   = 2'h3;
    localparam logic [1:0] PFX_RESET  = 2'h0;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    typedef enum logic [1:0] {DP_NONE, DP_PRE_INC, DP_POST_INC, DP_POST_DEC} mid_dp_mode_e;
endpackage : mid_pkg

// ==== core/mid_dec_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface mid_dec_if;
    logic       srcIsImm;
    logic [3:0] srcModule;
    logic [3:0] srcIndex;
    logic [7:0] immValue;
    logic [3:0] dstModule;
    logic [2:0] dstSub;
    modport dec (output srcIsImm, srcModule, srcIndex, immValue, dstModule, dstSub);
    modport core (input srcIsImm, srcModule, srcIndex, immValue, dstModule, dstSub);
endinterface : mid_dec_if
`default_nettype wire

// ==== core/mid_field_split.sv ====
`timescale 1ns/1ps
`default_nettype none
module mid_field_split (
    input  wire logic [15:0] instr,
    mid_dec_if.dec           fields
);
    // Format bit picks immediate or register source
    assign fields.srcIsImm  = (instr[mid_pkg::FMT_BIT] == mid_pkg::FMT_IMM);
    // Low byte source: module low nibble, index high nibble
    assign fields.immValue  = instr[mid_pkg::SRC_HI:mid_pkg::SRC_LO];
    assign fields.srcModule = instr[mid_pkg::SRC_MOD_LO +: mid_pkg::MOD_W];
    assign fields.srcIndex  = instr[mid_pkg::SRC_IDX_LO +: mid_pkg::SRC_IDX_W];
    // Destination always a register
    assign fields.dstModule = instr[mid_pkg::DST_MOD_LO +: mid_pkg::MOD_W];
    assign fields.dstSub    = instr[mid_pkg::DST_SUB_LO +: mid_pkg::DST_SUB_W];
endmodule : mid_field_split
`default_nettype wire

// ==== core/move_instruction_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module move_instruction_decoder (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] instrWord,
    input  wire logic [7:0]  srcReadData,
    input  wire logic [15:0] stackPushData,
    output logic      [15:0] fetchAddr,
    output logic             srcReadStrobe,
    output logic      [3:0]  srcModule,
    output logic      [3:0]  srcIndex,
    output logic             dstWriteStrobe,
    output logic      [3:0]  dstModule,
    output logic      [4:0]  dstIndex,
    output logic      [7:0]  dstWriteData,
    output logic             aluOpStrobe,
    output logic      [7:0]  accValue,
    output logic      [1:0]  stackLevelPointer,
    output logic      [15:0] stackTop,
    output logic      [1:0]  dpSelect,
    output logic             dpStepUp,
    output logic             dpStepDown,
    output logic             dpStepBefore
);
    mid_dec_if fields();

    mid_field_split u_split (
        .instr  (instrWord),
        .fields (fields.dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the current word, all within one cycle
    logic [1:0]  destinationPrefixRegister;
    logic        prefixWrite;
    logic [7:0]  srcValue;
    logic [4:0]  next_dstIndex;
    logic        isPush;
    logic        isPop;
    logic [15:0] stackMem [mid_pkg::STACK_DEPTH];

    assign prefixWrite   = (fields.dstModule == mid_pkg::MOD_PFX);
    // Extended index: prefix bits above subindex
    assign next_dstIndex = {destinationPrefixRegister, fields.dstSub};
    // Any register may be the source operand
    assign srcValue      = fields.srcIsImm ? fields.immValue : srcReadData;
    assign isPush        = (fields.dstModule == mid_pkg::MOD_SP)
                           && (fields.dstSub == mid_pkg::IDX_PUSH[2:0]);
    assign isPop         = !fields.srcIsImm && (fields.srcModule == mid_pkg::MOD_SP)
                           && (fields.srcIndex == mid_pkg::IDX_PUSH);

    // Combinational handshake strobes: read for register sources only, write for all but prefix words
    assign srcReadStrobe  = !sys_rst && !fields.srcIsImm;
    assign srcModule      = fields.srcModule;
    assign srcIndex       = fields.srcIndex;
    assign dstWriteStrobe = !sys_rst && !prefixWrite;
    assign dstModule      = fields.dstModule;
    assign aluOpStrobe    = dstWriteStrobe && (fields.dstModule == mid_pkg::MOD_ALU);

    ////////////////////////////////////////////////////////////////////////////
    // Registered destination data and index
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dstIndex     <= '0;
            dstWriteData <= '0;
        end else begin
            dstIndex     <= next_dstIndex;
            dstWriteData <= srcValue;
        end
    end

    // Prefix holds for exactly the next word, then clears
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            destinationPrefixRegister <= mid_pkg::PFX_RESET;
        end else if (prefixWrite) begin
            destinationPrefixRegister <= srcValue[mid_pkg::PFX_W-1:0];
        end else begin
            destinationPrefixRegister <= mid_pkg::PFX_RESET;
        end
    end

    // Program counter advances every cycle unless an IP write loads the source value
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fetchAddr <= mid_pkg::PC_RESET;
        end else if (fields.dstModule == mid_pkg::MOD_IP) begin
            fetchAddr <= {8'h00, srcValue};
        end else begin
            fetchAddr <= fetchAddr + 16'h0001;
        end
    end

    // Accumulator, 8 bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            accValue <= '0;
        end else if (fields.dstModule == mid_pkg::MOD_ACC) begin
            accValue <= srcValue;
        end else if (aluOpStrobe) begin
            accValue <= accValue + srcValue;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stack: pre-increment push, read-then-decrement pop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stackLevelPointer <= mid_pkg::SP_RESET;
        end else if (isPush) begin
            stackLevelPointer <= stackLevelPointer + 2'h1;
        end else if (isPop) begin
            stackLevelPointer <= stackLevelPointer - 2'h1;
        end
    end

    for (genvar e = 0; e < mid_pkg::STACK_DEPTH; e++) begin : g_stack
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                stackMem[e] <= '0;
            end else if (isPush && (stackLevelPointer + 2'h1) == 2'(e)) begin
                stackMem[e] <= stackPushData;
            end
        end
    end

    assign stackTop = stackMem[stackLevelPointer];

    ////////////////////////////////////////////////////////////////////////////
    // Data pointer auto-step control
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dpSelect     <= '0;
            dpStepUp     <= 1'b0;
            dpStepDown   <= 1'b0;
            dpStepBefore <= 1'b0;
        end else if (fields.dstModule == mid_pkg::MOD_DP) begin
            dpSelect     <= (fields.dstSub[1:0] < 2'(mid_pkg::NUM_DP)) ? fields.dstSub[1:0] : 2'h0;
            dpStepUp     <= (srcValue[1:0] == mid_pkg::DP_PRE_INC) || (srcValue[1:0] == mid_pkg::DP_POST_INC);
            dpStepDown   <= (srcValue[1:0] == mid_pkg::DP_POST_DEC);
            dpStepBefore <= (srcValue[1:0] == mid_pkg::DP_PRE_INC);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Multi-cycle behaviours the assertions below are built from
    sequence prefix_then_use_s;
        prefixWrite ##1 !prefixWrite;
    endsequence

    sequence push_then_idle_s;
        isPush ##1 (!isPush && !isPop);
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    // Transfer strobes and source fields
    prefix_skip_a: assert property (@(posedge clk) disable iff (sys_rst)
        prefixWrite |-> !dstWriteStrobe)
        else $error("prefix word wrote a destination");
    write_once_a: assert property (@(posedge clk) disable iff (sys_rst)
        !prefixWrite |-> dstWriteStrobe)
        else $error("missing write strobe");
    read_strobe_a: assert property (@(posedge clk) disable iff (sys_rst)
        srcReadStrobe == (instrWord[mid_pkg::FMT_BIT] != mid_pkg::FMT_IMM))
        else $error("read strobe wrong");
    src_field_a: assert property (@(posedge clk) disable iff (sys_rst)
        srcModule == instrWord[mid_pkg::SRC_MOD_LO +: mid_pkg::MOD_W]
        && srcIndex == instrWord[mid_pkg::SRC_IDX_LO +: mid_pkg::SRC_IDX_W])
        else $error("source field");
    reset_quiet_a: assert property (@(posedge clk)
        sys_rst |-> !srcReadStrobe && !dstWriteStrobe && !aluOpStrobe)
        else $error("strobe during reset");

    ////////////////////////////////////////////////////////////////////////////
    // Program flow and accumulator
    pc_step_a: assert property (@(posedge clk) disable iff (sys_rst)
        (dstModule != mid_pkg::MOD_IP) |=> fetchAddr == $past(fetchAddr) + 16'h0001)
        else $error("fetch address did not step");
    jump_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        (dstModule == mid_pkg::MOD_IP) |=> fetchAddr == {8'h00, $past(srcValue)})
        else $error("jump target not loaded");
    acc_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        (dstModule == mid_pkg::MOD_ACC) |=> accValue == $past(srcValue))
        else $error("acc load");
    alu_fire_a: assert property (@(posedge clk) disable iff (sys_rst)
        aluOpStrobe |=> accValue == $past(accValue) + $past(srcValue))
        else $error("alu side operation missing");

    ////////////////////////////////////////////////////////////////////////////
    // Destination prefix
    index_ext_a: assert property (@(posedge clk) disable iff (sys_rst)
        prefix_then_use_s |=> dstIndex[mid_pkg::DST_IDX_W-1 -: mid_pkg::PFX_W]
                              == $past(srcValue[mid_pkg::PFX_W-1:0], 2))
        else $error("prefix not applied");
    prefix_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        !prefixWrite |=> destinationPrefixRegister == mid_pkg::PFX_RESET)
        else $error("prefix stuck");

    ////////////////////////////////////////////////////////////////////////////
    // Stack and data pointers
    sp_reset_a: assert property (@(posedge clk)
        sys_rst |=> stackLevelPointer == mid_pkg::SP_RESET)
        else $error("sp reset value");
    sp_push_a: assert property (@(posedge clk) disable iff (sys_rst)
        isPush |=> stackLevelPointer == $past(stackLevelPointer) + 2'h1)
        else $error("push step");
    sp_pop_a: assert property (@(posedge clk) disable iff (sys_rst)
        isPop && !isPush |=> stackLevelPointer == $past(stackLevelPointer) - 2'h1)
        else $error("pop step");
    stack_store_a: assert property (@(posedge clk) disable iff (sys_rst)
        isPush |=> stackTop == $past(stackPushData))
        else $error("pushed value not on top");
    stack_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        push_then_idle_s |=> stackTop == $past(stackPushData, 2))
        else $error("pushed value lost");
    dp_exclusive_a: assert property (@(posedge clk) disable iff (sys_rst)
        !(dpStepUp && dpStepDown))
        else $error("data pointer steps both ways");
endmodule : move_instruction_decoder
`default_nettype wire

// ==== verification/mid_reg_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mid_reg_model (
    input  wire logic       clk,
    input  wire logic       srcReadStrobe,
    input  wire logic [3:0] srcModule,
    input  wire logic [3:0] srcIndex,
    output logic      [7:0] srcReadData
);
    logic [7:0] lastValue = 8'h00;

    // Unselected registers show a toggling pattern, never a held value
    always_comb begin
        if (srcReadStrobe) srcReadData = {srcIndex, srcModule} ^ 8'ha5;
        else srcReadData = ~lastValue;
    end

    always_ff @(posedge clk) begin
        lastValue <= srcReadData;
    end
endmodule : mid_reg_model
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; $display("unexpected at %0t got %h expected %h", $time, (a), (b)); end end
module tb;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] instrWord = 16'h0000;
    logic [15:0] stackPushData = 16'h0000;
    logic [7:0]  srcReadData, dstWriteData, accValue;
    logic [15:0] fetchAddr, stackTop;
    logic        srcReadStrobe, dstWriteStrobe, aluOpStrobe, dpStepUp, dpStepDown, dpStepBefore;
    logic [3:0]  srcModule, srcIndex, dstModule;
    logic [4:0]  dstIndex;
    logic [1:0]  stackLevelPointer, dpSelect;
    int          mismatches = 0;
    int          compares = 0;
    int          cycles = 0;

    always #12.5 clk = ~clk;

    move_instruction_decoder dut (.clk(clk), .sys_rst(sys_rst), .instrWord(instrWord), .srcReadData(srcReadData),
        .stackPushData(stackPushData), .fetchAddr(fetchAddr), .srcReadStrobe(srcReadStrobe),
        .srcModule(srcModule), .srcIndex(srcIndex), .dstWriteStrobe(dstWriteStrobe), .dstModule(dstModule),
        .dstIndex(dstIndex), .dstWriteData(dstWriteData), .aluOpStrobe(aluOpStrobe), .accValue(accValue),
        .stackLevelPointer(stackLevelPointer), .stackTop(stackTop), .dpSelect(dpSelect), .dpStepUp(dpStepUp),
        .dpStepDown(dpStepDown), .dpStepBefore(dpStepBefore));

    mid_reg_model regs (.clk(clk), .srcReadStrobe(srcReadStrobe), .srcModule(srcModule), .srcIndex(srcIndex),
        .srcReadData(srcReadData));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] w(logic fmt, logic [2:0] sub, logic [3:0] m, logic [7:0] src);
        return {fmt, sub, m, src};
    endfunction : w

    task automatic put(input logic [15:0] word);
        @(negedge clk);
        instrWord = word;
        #1;
    endtask : put

    task end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            mismatches++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic fields_test();
        put(w(1'b1, 3'h6, 4'h5, 8'h3a));
        `CHK(srcReadStrobe, 1'b1)
        `CHK({srcIndex, srcModule}, 8'h3a)
        `CHK(dstWriteStrobe, 1'b1)
        `CHK(dstModule, 4'h5)
        put(w(1'b0, 3'h1, 4'h2, 8'hc4));
        `CHK(srcReadStrobe, 1'b0)
        `CHK(dstIndex, 5'h06)
        `CHK(dstWriteData, 8'h3a ^ 8'ha5)
        put(w(1'b0, 3'h0, 4'h0, 8'h00));
        `CHK(dstWriteData, 8'hc4)
        `CHK(dstIndex, 5'h01)
    endtask : fields_test

    task automatic prefix_test();
        for (int p = 0; p < 4; p++) begin
            put(w(1'b0, 3'h0, 4'hb, 8'(p)));
            `CHK(dstWriteStrobe, 1'b0)
            put(w(1'b0, 3'h7, 4'h3, 8'h11));
            `CHK(dstWriteStrobe, 1'b1)
            put(w(1'b0, 3'h5, 4'h3, 8'h12));
            `CHK(dstIndex, {2'(p), 3'h7})
            put(w(1'b0, 3'h0, 4'h0, 8'h00));
            `CHK(dstIndex, 5'h05)
        end
    endtask : prefix_test

    task automatic acc_test();
        put(w(1'b0, 3'h0, 4'h9, 8'h30));
        put(w(1'b0, 3'h0, 4'h8, 8'h15));
        `CHK(aluOpStrobe, 1'b1)
        put(w(1'b1, 3'h0, 4'h8, 8'h32));
        `CHK(accValue, 8'h45)
        put(w(1'b0, 3'h0, 4'h0, 8'h00));
        `CHK(aluOpStrobe, 1'b0)
        `CHK(accValue, 8'h45 + (8'h32 ^ 8'ha5))
    endtask : acc_test

    task automatic stack_test();
        put(w(1'b0, 3'h0, 4'hd, 8'h00));
        stackPushData = 16'h1234;
        put(w(1'b0, 3'h0, 4'hd, 8'h00));
        stackPushData = 16'hbeef;
        `CHK(stackLevelPointer, 2'h0)
        `CHK(stackTop, 16'h1234)
        put(w(1'b1, 3'h0, 4'h0, 8'h0d));
        `CHK(stackLevelPointer, 2'h1)
        `CHK(stackTop, 16'hbeef)
        put(w(1'b0, 3'h0, 4'h0, 8'h00));
        `CHK(stackLevelPointer, 2'h0)
        `CHK(stackTop, 16'h1234)
    endtask : stack_test

    task automatic dp_test();
        for (int m = 0; m < 4; m++) begin
            put(w(1'b0, 3'h1, 4'hf, 8'(m)));
            put(w(1'b0, 3'h0, 4'h0, 8'h00));
            `CHK({dpStepUp, dpStepDown, dpStepBefore}, {m == 1 || m == 2, m == 3, m == 1})
            `CHK(dpSelect, 2'h1)
        end
    endtask : dp_test

    task automatic jump_test();
        put(w(1'b0, 3'h0, 4'hc, 8'h40));
        put(w(1'b0, 3'h0, 4'h0, 8'h00));
        `CHK(fetchAddr, 16'h0040)
        put(w(1'b0, 3'h0, 4'h0, 8'h00));
        `CHK(fetchAddr, 16'h0041)
    endtask : jump_test

    task automatic reset_test();
        @(negedge clk);
        sys_rst = 1'b1;
        instrWord = w(1'b1, 3'h0, 4'hd, 8'h00);
        #1;
        `CHK(srcReadStrobe, 1'b0)
        `CHK(dstWriteStrobe, 1'b0)
        @(negedge clk);
        `CHK(stackLevelPointer, 2'h3)
        `CHK(fetchAddr, 16'h0000)
        `CHK(accValue, 8'h00)
        `CHK(dpSelect, 2'h0)
        @(negedge clk);
        sys_rst = 1'b0;
        `CHK(stackTop, 16'h0000)
        put(w(1'b0, 3'h0, 4'h0, 8'h00));
        `CHK(stackLevelPointer, 2'h0)
        `CHK(stackTop, 16'hbeef)
        `CHK(fetchAddr, 16'h0001)
        repeat (2) put(w(1'b0, 3'h0, 4'h0, 8'h00));
        `CHK(stackTop, 16'hbeef)
    endtask : reset_test

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        `CHK(stackLevelPointer, 2'h3)
        `CHK(fetchAddr, 16'h0000)
        `CHK(accValue, 8'h00)
        fields_test();
        prefix_test();
        acc_test();
        stack_test();
        dp_test();
        jump_test();
        reset_test();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
